// ==== srwd_cfg.svh ====
// Constants of the supervisory reset and watchdog block.
// Assumes a 40 MHz bus clock and a 10.24 kHz internal timebase.
`ifndef SRWD_CFG_SVH
`define SRWD_CFG_SVH
`define SRWD_HCLK_HZ 40000000
`define SRWD_INT_OSC_HZ 10240
`define SRWD_SHORT_MS 100
`define SRWD_LONG_MS 1600
`define SRWD_RST_MS 50
`define SRWD_EXT_NORMAL_CLKS 1024
`define SRWD_EXT_LONG_CLKS 4096
`define SRWD_EXT_RST_CLKS 512
`define SRWD_CTRL_OFS 8'h00
`define SRWD_STATUS_OFS 8'h04
`define SRWD_COUNT_OFS 8'h08
`define SRWD_CTRL_EN_BIT 0
`define SRWD_CTRL_RESET 32'h0000_0001
`endif

// ==== srwd_pkg.sv ====
// Types of the supervisory reset and watchdog block.
// Assumes nothing beyond the constant header.
package srwd_pkg;
   typedef enum logic [1:0] {SRWD_HOLD, SRWD_STRETCH, SRWD_WATCH} srwd_state_t;
endpackage : srwd_pkg

// ==== srwd_top.sv ====
// Supervisory reset generator, watchdog, RAM enable gate and power-fail pass.
// Assumes comparator results arrive as digital flags synchronous to hclk.
//
// Function
// - Hold active-low reset while supply is low.
// - Stretch reset one active period after recovery.
// - Active-high reset is complement of active-low.
// - Missing kick transition causes a reset pulse.
// - Long timeout applies right after any reset.
// - Watchdog restarts when any reset ends.
// - First kick after reset selects normal timeout, except internal timebase with timebase_in high.
// - Every kick edge restarts the timeout count.
// - Stuck kick repeats reset each long timeout.
// - Floating or mid-level kick disables watchdog.
// - Select high uses internal oscillator, low external.
// - External clocks: 1024 normal, 4096 long, 512.
// - Internal: 100 ms or 1.6 s, 50 ms.
// - Expired flag low until next kick edge.
// - Expired flag forced high during undervoltage.
// - Chip enable passes, forced high on undervoltage.
// - Power-fail warning low while its input low.
// - Backup mode forces fixed output levels.
// - Backup mode ignores inputs, disables power-fail.
// - Backup when supply low and main below battery.
// - Undervoltage flag low while supply sense low.
// - Backup indicator high while fed from battery.
//
// The AHB-Lite slave port and the register offsets are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
`include "srwd_cfg.svh"
module srwd_top
   import srwd_pkg::*;
#(
   parameter int INT_DIV = `SRWD_HCLK_HZ / `SRWD_INT_OSC_HZ,
   parameter int EXT_NORMAL = `SRWD_EXT_NORMAL_CLKS,
   parameter int EXT_LONG = `SRWD_EXT_LONG_CLKS,
   parameter int EXT_RST = `SRWD_EXT_RST_CLKS,
   parameter int INT_SHORT = `SRWD_SHORT_MS * `SRWD_INT_OSC_HZ / 1000,
   parameter int INT_LONG = `SRWD_LONG_MS * `SRWD_INT_OSC_HZ / 1000,
   parameter int INT_RST = `SRWD_RST_MS * `SRWD_INT_OSC_HZ / 1000
)
(
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [7:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   input wire logic supply_low,
   input wire logic main_below_backup,
   input wire logic power_fail_low,
   input wire logic watchdog_kick_in,
   input wire logic kick_float,
   input wire logic timebase_select,
   input wire logic timebase_in,
   input wire logic ram_ce_in_n,
   output logic reset_n,
   output logic reset_hi,
   output logic low_line_n,
   output logic backup_active,
   output logic watchdog_expired_n,
   output logic power_fail_warn_n,
   output logic ram_ce_out_n
);
   localparam int CW = 15;
   srwd_state_t st_q, st_d;
   logic [CW-1:0] cnt_q, cnt_d;
   logic [11:0] div_q;
   logic long_q, long_d;
   logic kick_prev_q, tb_prev_q;
   logic tick, kick_edge, backup, wd_en, timeout;
   logic [CW-1:0] limit, rst_len;
   logic [31:0] ctrl_q;
   logic wr_pend_q;
   logic [7:0] wr_addr_q;
   logic reset_n_q, reset_hi_q, low_line_n_q, backup_q, wdo_n_q, pfo_n_q, ce_n_q;
   logic [31:0] hrdata_q;
   logic hreadyout_q;

   assign backup = supply_low & main_below_backup;
   assign wd_en = ctrl_q[`SRWD_CTRL_EN_BIT] & ~kick_float;
   assign kick_edge = (watchdog_kick_in != kick_prev_q) & wd_en;

   // Timebase: internal divider or rising edges of the external pin
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         div_q <= 12'h000;
         tb_prev_q <= 1'b0;
         kick_prev_q <= 1'b0;
      end
      else
      begin
         tb_prev_q <= timebase_in;
         kick_prev_q <= watchdog_kick_in;
         if (div_q == 12'(INT_DIV - 1))
            div_q <= 12'h000;
         else
            div_q <= div_q + 12'h001;
      end
   end

   // Backup freezes the timebase, so oscillator select is ignored there
   always_comb
   begin
      if (backup)
         tick = 1'b0;
      else if (timebase_select)
         tick = (div_q == 12'(INT_DIV - 1));
      else
         tick = timebase_in & ~tb_prev_q;
   end

   always_comb
   begin
      if (!timebase_select)
      begin
         rst_len = CW'(EXT_RST);
         limit = long_q ? CW'(EXT_LONG) : CW'(EXT_NORMAL);
      end
      else
      begin
         rst_len = CW'(INT_RST);
         if (long_q || timebase_in)
            limit = CW'(INT_LONG);
         else
            limit = CW'(INT_SHORT);
      end
   end

   assign timeout = (st_q == SRWD_WATCH) & wd_en & ~kick_edge & tick & ~backup
                    & (cnt_q == limit - CW'(1));

   always_comb
   begin
      st_d = st_q;
      cnt_d = cnt_q;
      long_d = long_q;
      if (supply_low)
      begin
         st_d = SRWD_HOLD;
         cnt_d = '0;
         long_d = 1'b1;
      end
      else
      begin
         unique case (st_q)
            SRWD_HOLD:
            begin
               st_d = SRWD_STRETCH;
               cnt_d = '0;
            end
            SRWD_STRETCH:
            begin
               if (tick)
               begin
                  if (cnt_q == rst_len - CW'(1))
                  begin
                     st_d = SRWD_WATCH;
                     cnt_d = '0;
                     long_d = 1'b1;
                  end
                  else
                     cnt_d = cnt_q + CW'(1);
               end
            end
            SRWD_WATCH:
            begin
               if (!wd_en)
                  cnt_d = '0;
               else if (kick_edge)
               begin
                  cnt_d = '0;
                  long_d = 1'b0;
               end
               else if (timeout)
               begin
                  st_d = SRWD_STRETCH;
                  cnt_d = '0;
               end
               else if (tick)
                  cnt_d = cnt_q + CW'(1);
            end
         endcase
      end
   end

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         st_q <= SRWD_HOLD;
         cnt_q <= '0;
         long_q <= 1'b1;
      end
      else
      begin
         st_q <= st_d;
         cnt_q <= cnt_d;
         long_q <= long_d;
      end
   end

   // Pin outputs, registered so none glitches on comparator edges
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         reset_n_q <= 1'b0;
         reset_hi_q <= 1'b1;
         low_line_n_q <= 1'b0;
         backup_q <= 1'b0;
         wdo_n_q <= 1'b1;
         pfo_n_q <= 1'b1;
         ce_n_q <= 1'b1;
      end
      else
      begin
         reset_n_q <= ~supply_low & (st_d == SRWD_WATCH);
         reset_hi_q <= ~(~supply_low & (st_d == SRWD_WATCH));
         low_line_n_q <= ~supply_low;
         backup_q <= backup;
         ce_n_q <= supply_low | ram_ce_in_n;
         if (backup)
            pfo_n_q <= 1'b0;
         else
            pfo_n_q <= ~power_fail_low;
         // A kick in the terminal tick masks the timeout, so the flag stays high
         if (supply_low)
            wdo_n_q <= 1'b1;
         else if (timeout)
            wdo_n_q <= 1'b0;
         else if (kick_edge)
            wdo_n_q <= 1'b1;
      end
   end

   // AHB-Lite slave: zero wait states, read data prepared in the address phase
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         wr_pend_q <= 1'b0;
         wr_addr_q <= 8'h00;
         hrdata_q <= 32'h0000_0000;
         hreadyout_q <= 1'b1;
      end
      else
      begin
         hreadyout_q <= 1'b1;
         wr_pend_q <= 1'b0;
         if (hsel && htrans[1] && hready)
         begin
            wr_pend_q <= hwrite;
            wr_addr_q <= haddr;
            hrdata_q <= 32'h0000_0000;
            if (!hwrite)
            begin
               unique case (haddr)
                  `SRWD_CTRL_OFS: hrdata_q <= ctrl_q;
                  `SRWD_STATUS_OFS: hrdata_q <= {24'h000000, long_q, 1'b0,
                     ce_n_q, pfo_n_q, wdo_n_q, backup_q, low_line_n_q, reset_n_q};
                  `SRWD_COUNT_OFS: hrdata_q <= {17'h00000, cnt_q};
                  default: hrdata_q <= 32'h0000_0000;
               endcase
            end
         end
      end
   end

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         ctrl_q <= `SRWD_CTRL_RESET;
      else if (wr_pend_q && wr_addr_q == `SRWD_CTRL_OFS)
         ctrl_q <= {31'h00000000, hwdata[`SRWD_CTRL_EN_BIT]};
   end

   assign hrdata = hrdata_q;
   assign hreadyout = hreadyout_q;
   assign hresp = 1'b0;
   assign reset_n = reset_n_q;
   assign reset_hi = reset_hi_q;
   assign low_line_n = low_line_n_q;
   assign backup_active = backup_q;
   assign watchdog_expired_n = wdo_n_q;
   assign power_fail_warn_n = pfo_n_q;
   assign ram_ce_out_n = ce_n_q;

   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);

   rst_hold_a: assert property (supply_low |=> !reset_n_q)
      else $error("reset not held during undervoltage");
   rst_compl_a: assert property (reset_hi_q == !reset_n_q)
      else $error("reset outputs not complementary");
   rst_stretch_a: assert property ($rose(reset_n_q) |-> $past(st_q) == SRWD_STRETCH
      && $past(cnt_q) == rst_len - CW'(1))
      else $error("reset released before active period");
   long_after_a: assert property ($rose(reset_n_q) |-> long_q && cnt_q == '0)
      else $error("long timeout or restart missing after reset");
   kick_restart_a: assert property (st_q == SRWD_WATCH && kick_edge && !supply_low
      |=> cnt_q == '0 && !long_q)
      else $error("kick did not restart count");
   float_off_a: assert property (kick_float && st_q == SRWD_WATCH && !supply_low
      |=> cnt_q == '0 && reset_n_q)
      else $error("watchdog active while kick floats");
   wdo_expire_a: assert property (timeout && !supply_low
      |=> !wdo_n_q && !reset_n_q)
      else $error("timeout did not drop flag and reset");
   wdo_under_a: assert property (supply_low |=> wdo_n_q)
      else $error("expired flag low during undervoltage");
   ce_gate_a: assert property (supply_low |=> ce_n_q)
      else $error("chip enable passed during undervoltage");
   pfo_pass_a: assert property (!backup |=> pfo_n_q == !$past(power_fail_low))
      else $error("power fail warning wrong");
   backup_out_a: assert property (backup |=> !reset_n_q && reset_hi_q && !low_line_n_q
      && backup_q && wdo_n_q && !pfo_n_q && ce_n_q)
      else $error("backup output levels wrong");

   // Flag and kick checks; the flags are taken as already synchronous to hclk,
   // so a raw comparator pin here would need a synchroniser in front.
   wdo_hold_a: assert property (!wdo_n_q && !kick_edge && !supply_low
      |=> !wdo_n_q)
      else $error("expired flag released without a kick");
   wdo_clear_a: assert property (kick_edge && !supply_low
      |=> wdo_n_q)
      else $error("kick did not release expired flag");
   wdo_float_a: assert property (kick_float && wdo_n_q && !supply_low
      |=> wdo_n_q)
      else $error("expired flag dropped while kick floats");
   kick_once_a: assert property (kick_edge
      |=> !kick_edge || $changed(watchdog_kick_in))
      else $error("one kick change counted twice");
   long_hold_a: assert property (long_q && !kick_edge && !supply_low
      |=> long_q)
      else $error("long timeout left without a kick");

   // Supply side checks
   ce_pass_a: assert property (!supply_low
      |=> ce_n_q == $past(ram_ce_in_n))
      else $error("chip enable not passed through");
   low_line_a: assert property (!supply_low
      |=> low_line_n_q)
      else $error("undervoltage flag low with good supply");
   backup_frz_a: assert property (backup
      |=> st_q == SRWD_HOLD && cnt_q == '0)
      else $error("watchdog running in backup");
   tick_frz_a: assert property (backup
      |-> !tick)
      else $error("timebase running in backup");

   wd_reset_c: cover property (timeout);
   kick_c: cover property (st_q == SRWD_WATCH && kick_edge && long_q);
   backup_c: cover property ($rose(backup_q));
   release_c: cover property ($rose(reset_n_q));
   float_c: cover property (kick_float && st_q == SRWD_WATCH);
endmodule : srwd_top
`default_nettype wire

// ==== srwd_host_model.sv ====
// Host side model: kicks the watchdog at a set interval and drives RAM enable.
// Assumes hclk free running and the device's active-low reset output.
`timescale 1ns/1ps
`default_nettype none
module srwd_host_model
(
   input wire logic hclk,
   input wire logic reset_n,
   input wire logic kick_en,
   input wire logic [7:0] period,
   input wire logic ce_req,
   output logic watchdog_kick_in,
   output logic ram_ce_in_n
);
   logic [7:0] cnt_q = 8'h00;
   logic kick_q = 1'b0;
   // Kick holds its last level while held in reset
   always @(posedge hclk)
   begin
      if (!reset_n || !kick_en)
         cnt_q <= 8'h00;
      else if (cnt_q >= period)
      begin
         cnt_q <= 8'h00;
         kick_q <= ~kick_q;
      end
      else
         cnt_q <= cnt_q + 8'h01;
   end
   assign watchdog_kick_in = kick_q;
   assign ram_ce_in_n = ~ce_req;
endmodule : srwd_host_model
`default_nettype wire

// ==== srwd_top_tb.sv ====
// Self-checking bench for the supervisory reset and watchdog block.
// Assumes shortened counts; one internal tick every four hclk cycles.
`timescale 1ns/1ps
`default_nettype none
module srwd_top_tb;
   import srwd_pkg::*;
   localparam int DIV = 4, NRM = 8, LNG = 16, RST = 4;
   logic hclk, hresetn, hsel, hwrite, hready, hresp;
   logic [7:0] haddr, period;
   logic [1:0] htrans;
   logic [31:0] hwdata, hrdata, rd;
   logic supply_low, main_below_backup, power_fail_low, kick_float, timebase_select;
   logic timebase_in, watchdog_kick_in, ram_ce_in_n, kick_en, ce_req, tb_run;
   logic reset_n, reset_hi, low_line_n, backup_active, watchdog_expired_n;
   logic power_fail_warn_n, ram_ce_out_n;
   logic [1:0] tb_cnt = 2'h0;
   int miscompares = 0, checks_done = 0, n;
   srwd_top #(.INT_DIV(DIV), .EXT_NORMAL(NRM), .EXT_LONG(LNG), .EXT_RST(RST),
      .INT_SHORT(NRM), .INT_LONG(LNG), .INT_RST(RST)) srwd_top_inst (.hclk(hclk),
      .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
      .hsize(3'h2), .hwdata(hwdata), .hready(hready), .hrdata(hrdata), .hreadyout(hready),
      .hresp(hresp), .supply_low(supply_low), .main_below_backup(main_below_backup),
      .power_fail_low(power_fail_low), .watchdog_kick_in(watchdog_kick_in),
      .kick_float(kick_float), .timebase_select(timebase_select),
      .timebase_in(timebase_in), .ram_ce_in_n(ram_ce_in_n), .reset_n(reset_n),
      .reset_hi(reset_hi), .low_line_n(low_line_n), .backup_active(backup_active),
      .watchdog_expired_n(watchdog_expired_n), .power_fail_warn_n(power_fail_warn_n),
      .ram_ce_out_n(ram_ce_out_n));
   srwd_host_model srwd_host_model_inst (.hclk(hclk), .reset_n(reset_n),
      .kick_en(kick_en), .period(period), .ce_req(ce_req),
      .watchdog_kick_in(watchdog_kick_in), .ram_ce_in_n(ram_ce_in_n));
   initial
   begin
      hclk = 1'b0;
      forever #12.5 hclk = ~hclk;
   end
   // External timebase: one rising edge every six hclk cycles
   always @(posedge hclk)
   begin
      tb_cnt <= (tb_cnt == 2'h2) ? 2'h0 : tb_cnt + 2'h1;
      if (tb_run && tb_cnt == 2'h2)
         timebase_in <= ~timebase_in;
   end
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp)
      begin
         miscompares++;
         $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
      end
   endtask : check
   task automatic rng(input int v, input int lo, input int hi);
      check(32'(v >= lo && v <= hi), 32'h1);
   endtask : rng
   // Single word transfer; waits on hready, never on a fixed count
   task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
      @(posedge hclk);
      hsel <= 1'b1;
      htrans <= 2'b10;
      haddr <= a;
      hwrite <= wr;
      do @(posedge hclk); while (hready !== 1'b1);
      htrans <= 2'b00;
      hsel <= 1'b0;
      hwdata <= wd;
      do @(posedge hclk); while (hready !== 1'b1);
      rd = hrdata;
   endtask : ahb
   // Counts falling edges until the signal shows the level, up to lim
   task automatic wait_for(ref logic s, input logic v, input int lim, output int cnt);
      cnt = 0;
      while (s !== v && cnt < lim)
      begin
         @(negedge hclk);
         cnt++;
      end
   endtask : wait_for
   task automatic stop_test;
      $display("checks_done=%0d miscompares=%0d", checks_done, miscompares);
      if (miscompares == 0 && checks_done > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask : stop_test
   initial
   begin
      #400000;
      miscompares++;
      stop_test();
   end
   initial
   begin
      {hresetn, hsel, hwrite, supply_low, main_below_backup, power_fail_low} = '0;
      {kick_float, timebase_in, kick_en, ce_req, tb_run} = '0;
      {timebase_select, period, htrans, haddr, hwdata} = {1'b1, 8'h06, 2'h0, 8'h00, 32'h0};
      repeat (10) @(posedge hclk);
      hresetn <= 1'b1;
      @(negedge hclk);
      check({reset_n, reset_hi}, 2'b01);
      wait_for(reset_n, 1'b1, 100, n);
      rng(n, RST * DIV, (RST + 2) * DIV + 2);
      check(reset_hi, 1'b0);
      // Stuck kick: two long timeouts, each timed from reset release
      repeat (2)
      begin
         wait_for(reset_n, 1'b1, 100, n);
         wait_for(reset_n, 1'b0, 200, n);
         rng(n, (LNG - 1) * DIV - 2, LNG * DIV + 2);
         @(negedge hclk);
         check({reset_n, watchdog_expired_n}, 2'b00);
         wait_for(reset_n, 1'b1, 100, n);
         check(watchdog_expired_n, 1'b0);
      end
      ahb(1'b0, 8'h00, 32'h0);
      check(rd, 32'h1);
      check(hresp, 1'b0);
      ahb(1'b0, 8'h0c, 32'h0);
      check(rd, 32'h0);
      ahb(1'b0, 8'h04, 32'h0);
      check(rd[7], 1'b1);
      ahb(1'b1, 8'h00, 32'h0);
      ahb(1'b0, 8'h00, 32'h0);
      check(rd, 32'h0);
      ahb(1'b1, 8'h00, 32'h1);
      kick_en <= 1'b1;
      repeat (100) @(negedge hclk);
      check({reset_n, watchdog_expired_n}, 2'b11);
      ahb(1'b0, 8'h04, 32'h0);
      check(rd[7], 1'b0);
      @(posedge hclk);
      kick_en <= 1'b0;
      wait_for(watchdog_expired_n, 1'b0, 200, n);
      rng(n, (NRM - 1) * DIV - 8, NRM * DIV + 2);
      @(posedge hclk);
      kick_float <= 1'b1;
      wait_for(reset_n, 1'b1, 100, n);
      wait_for(reset_n, 1'b0, 150, n);
      check(n, 150);
      @(posedge hclk);
      {supply_low, power_fail_low, ce_req, kick_float} <= 4'b1110;
      repeat (2) @(negedge hclk);
      check({reset_n, low_line_n, watchdog_expired_n, ram_ce_out_n, power_fail_warn_n},
         5'b00110);
      @(posedge hclk);
      {main_below_backup, power_fail_low, timebase_select} <= 3'b100;
      repeat (2) @(negedge hclk);
      check({reset_n, reset_hi, low_line_n, backup_active, watchdog_expired_n,
         power_fail_warn_n, ram_ce_out_n}, 7'b0101101);
      @(posedge hclk);
      {supply_low, main_below_backup} <= 2'b00;
      wait_for(reset_n, 1'b1, 100, n);
      check(n, 100);
      check(ram_ce_out_n, 1'b0);
      @(posedge hclk);
      tb_run <= 1'b1;
      wait_for(reset_n, 1'b1, 200, n);
      rng(n, RST * 6 - 8, RST * 6 + 8);
      wait_for(watchdog_expired_n, 1'b0, 300, n);
      rng(n, LNG * 6 - 8, LNG * 6 + 8);
      stop_test();
   end
endmodule : srwd_top_tb
`default_nettype wire
